// ### logic/psc_stage.sv
// Programmable stage: scaling, four comparators, ratios, timers, register port
`timescale 1ns/1ps
module psc_stage
	import psc_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
)
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [VAL_W-1:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic [VAL_W-1:0] rd_data,
	input  wire logic [VAL_W-1:0] measured_magnitude_one,
	input  wire logic [VAL_W-1:0] measured_magnitude_two,
	input  wire logic [VAL_W-1:0] measured_magnitude_three,
	input  wire logic        block_request,
	input  wire logic        allow_node_mode,
	output logic             start,
	output logic             trip,
	output logic             blocked
);
	typedef struct packed {
		logic [TICK_W-1:0]            tick_cnt;
		logic                         tick;
		logic                         tick_d;
		psc_node_mode_type            node_mode;
		logic [NCH-1:0]               ch_en;
		logic [31:0]                  mult;
		logic [DLY_W-1:0]             op_delay;
		logic [DLY_W-1:0]             rel_delay;
		logic [DLY_W-1:0]             op_cnt;
		logic [DLY_W-1:0]             rel_cnt;
		logic [NCH-1:0][2:0]          cmp_mode;
		logic [NCH-1:0][VAL_W-1:0]    level;
		logic [NCH-1:0][VAL_W-1:0]    blk_lim;
		logic [NCH-1:0][HYST_W-1:0]   hyst;
		logic [NCH-1:0][VAL_W-1:0]    scaled;
		logic [NCH-1:0][VAL_W-1:0]    ratio;
		psc_stage_type                stage;
		logic                         trip_int;
		logic                         start_o;
		logic                         trip_o;
		logic                         blocked_o;
		logic [1:0]                   div_ch;
		logic [6:0]                   div_cnt;
		logic [48:0]                  div_rem;
		logic [63:0]                  div_quo;
		logic [VAL_W-1:0]             div_den;
		logic                         div_neg;
		logic [VAL_W-1:0]             rd_data;
	} psc_state_type;

	psc_state_type        s_r;
	psc_state_type        s_nxt;
	logic [NCH-1:0]       pick;
	logic                 pick_any;
	logic                 blk;
	psc_cond_type         cond_now;
	logic [31:0]          remain_ms;
	logic [31:0]          expect_ms;
	logic [VAL_W-1:0]     meas [NMEAS];
	logic signed [127:0]  prod;
	logic signed [127:0]  csum;
	logic [63:0]          num;
	logic [63:0]          qmag;
	logic [48:0]          rem_s;
	logic signed [VAL_W-1:0] dv;
	logic signed [VAL_W-1:0] dl;
	logic signed [VAL_W-1:0] wv;
	logic [1:0]           ch;

	// Saturates a wide signed result into the displayed value range
	function automatic logic [VAL_W-1:0] sat_val(input logic signed [127:0] x);
		logic [VAL_W-1:0] r;
		if (x > 128'(VAL_LIMIT))
			r = VAL_LIMIT;
		else if (x < -128'(VAL_LIMIT))
			r = -VAL_LIMIT;
		else
			r = x[VAL_W-1:0];
		return r;
	endfunction

	assign meas[0] = measured_magnitude_one;
	assign meas[1] = measured_magnitude_two;
	assign meas[2] = measured_magnitude_three;

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gen_cmp
			psc_cmp_if cif ();
			assign cif.mode    = psc_cmp_mode_type'(s_r.cmp_mode[g]);
			assign cif.level   = s_r.level[g];
			assign cif.blk_lim = s_r.blk_lim[g];
			assign cif.hyst    = s_r.hyst[g];
			assign cif.value   = s_r.scaled[g];
			assign cif.tick    = s_r.tick;
			assign pick[g]     = cif.pick;
			psc_cmp u_cmp (
				.clock (clock),
				.rst_n (rst_n),
				.bus   (cif)
			);
		end
	endgenerate

	assign pick_any = |(pick & s_r.ch_en);
	assign blk = block_request || (s_r.node_mode == NODE_BLOCKED) ||
		(s_r.node_mode == NODE_TEST_BLOCKED);

	always_comb
	begin
		if (s_r.trip_int)
			cond_now = COND_TRIP;
		else if (s_r.start_o)
			cond_now = COND_START;
		else if (s_r.blocked_o)
			cond_now = COND_BLOCKED;
		else
			cond_now = COND_NORMAL;
	end

	// Countdown only while timing towards trip; zero otherwise
	assign remain_ms = (s_r.start_o && !s_r.trip_int) ?
		32'(s_r.op_delay - s_r.op_cnt) * 32'(TICK_TIME_MS) : 32'h0;
	assign expect_ms = 32'(s_r.op_delay) * 32'(TICK_TIME_MS);

	always_comb
	begin
		s_nxt = s_r;
		prod = '0;
		csum = '0;
		num = '0;
		qmag = '0;
		rem_s = '0;
		dv = '0;
		dl = '0;
		wv = $signed(wr_data);
		ch = addr[4:3];
		s_nxt.tick = 1'b0;
		s_nxt.tick_d = s_r.tick;
		s_nxt.rd_data = '0;
		if (s_r.tick_cnt == TICK_W'(TICK_CYC - 1))
		begin
			s_nxt.tick_cnt = '0;
			s_nxt.tick = 1'b1;
		end
		else
			s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;

		for (int k = 0; k < NMEAS; k++)
		begin
			prod = $signed(meas[k]) * $signed(s_r.mult);
			s_nxt.scaled[k] = sat_val(prod >>> MULT_FRAC);
			csum = csum + $signed(s_nxt.scaled[k]);
		end
		// The calculated channel is the sum of the three scaled inputs
		s_nxt.scaled[NCH-1] = sat_val(csum);

		// Serial divider shared by the channels; one ratio every 66 cycles, so each refreshes every 264 cycles
		dv = $signed(s_r.scaled[s_r.div_ch]);
		dl = $signed(s_r.level[s_r.div_ch]);
		if (s_r.div_cnt == 7'h00)
		begin
			num = 64'($unsigned(dv[VAL_W-1] ? -dv : dv)) * 64'(FRAC_SCALE);
			s_nxt.div_quo = num;
			s_nxt.div_rem = '0;
			s_nxt.div_den = dl[VAL_W-1] ? -dl : dl;
			s_nxt.div_neg = dv[VAL_W-1] ^ dl[VAL_W-1];
			s_nxt.div_cnt = 7'h01;
		end
		else if (s_r.div_cnt <= 7'h40)
		begin
			rem_s = {s_r.div_rem[47:0], s_r.div_quo[63]};
			if (rem_s >= {1'b0, s_r.div_den})
			begin
				s_nxt.div_rem = rem_s - {1'b0, s_r.div_den};
				s_nxt.div_quo = {s_r.div_quo[62:0], 1'b1};
			end
			else
			begin
				s_nxt.div_rem = rem_s;
				s_nxt.div_quo = {s_r.div_quo[62:0], 1'b0};
			end
			s_nxt.div_cnt = s_r.div_cnt + 7'h01;
		end
		else
		begin
			// A zero level gives the full-scale ratio instead of a divide fault
			if ((s_r.div_den == '0) || (s_r.div_quo > 64'(VAL_LIMIT)))
				qmag = 64'(VAL_LIMIT);
			else
				qmag = s_r.div_quo;
			s_nxt.ratio[s_r.div_ch] = s_r.div_neg ? -qmag[VAL_W-1:0] : qmag[VAL_W-1:0];
			s_nxt.div_ch = s_r.div_ch + 2'h1;
			s_nxt.div_cnt = 7'h00;
		end

		if (wr_en)
		begin
			if (addr[7:5] == CH_REGION)
			begin
				case (addr[2:0])
					CHOFS_MODE:
						s_nxt.cmp_mode[ch] = wr_data[2:0];
					CHOFS_LEVEL:
						if (wv > VAL_LIMIT)
							s_nxt.level[ch] = VAL_LIMIT;
						else if (wv < -VAL_LIMIT)
							s_nxt.level[ch] = -VAL_LIMIT;
						else
							s_nxt.level[ch] = wr_data;
					CHOFS_HYST:
						s_nxt.hyst[ch] = (wr_data > VAL_W'(HYST_MAX)) ?
							HYST_MAX : wr_data[HYST_W-1:0];
					CHOFS_BLK:
						s_nxt.blk_lim[ch] = wr_data;
					default:
						s_nxt.blk_lim[ch] = s_r.blk_lim[ch];
				endcase
			end
			else
			begin
				case (addr)
					ADDR_CTRL:
					begin
						if (wr_data[2:0] <= 3'h4)
							s_nxt.node_mode = psc_node_mode_type'(wr_data[2:0]);
						s_nxt.ch_en = wr_data[CTRL_EN_LSB +: NCH];
					end
					ADDR_MULT:
						s_nxt.mult = wr_data[31:0];
					ADDR_OP_DELAY:
						s_nxt.op_delay = (wr_data > VAL_W'(DELAY_MAX)) ?
							DELAY_MAX : wr_data[DLY_W-1:0];
					ADDR_REL_DELAY:
						s_nxt.rel_delay = (wr_data > VAL_W'(DELAY_MAX)) ?
							DELAY_MAX : wr_data[DLY_W-1:0];
					default:
						s_nxt.mult = s_r.mult;
				endcase
			end
		end

		if (rd_en)
		begin
			if (addr[7:5] == CH_REGION)
			begin
				case (addr[2:0])
					CHOFS_MODE:   s_nxt.rd_data = VAL_W'(s_r.cmp_mode[ch]);
					CHOFS_LEVEL:  s_nxt.rd_data = s_r.level[ch];
					CHOFS_HYST:   s_nxt.rd_data = VAL_W'(s_r.hyst[ch]);
					CHOFS_BLK:    s_nxt.rd_data = s_r.blk_lim[ch];
					CHOFS_RATIO:  s_nxt.rd_data = s_r.ratio[ch];
					CHOFS_SCALED: s_nxt.rd_data = s_r.scaled[ch];
					default:      s_nxt.rd_data = '0;
				endcase
			end
			else
			begin
				case (addr)
					ADDR_CTRL:
					begin
						// Mode stays hidden unless individual node modes are permitted
						if (allow_node_mode)
							s_nxt.rd_data[2:0] = s_r.node_mode;
						s_nxt.rd_data[CTRL_EN_LSB +: NCH] = s_r.ch_en;
					end
					ADDR_MULT:      s_nxt.rd_data = VAL_W'($signed(s_r.mult));
					ADDR_OP_DELAY:  s_nxt.rd_data = VAL_W'(s_r.op_delay);
					ADDR_REL_DELAY: s_nxt.rd_data = VAL_W'(s_r.rel_delay);
					ADDR_STATUS:
					begin
						s_nxt.rd_data[1:0] = cond_now;
						s_nxt.rd_data[STAT_START] = s_r.start_o;
						s_nxt.rd_data[STAT_TRIP] = s_r.trip_int;
						s_nxt.rd_data[STAT_BLOCKED] = s_r.blocked_o;
						s_nxt.rd_data[STAT_PICK +: NCH] = pick;
					end
					ADDR_REMAIN:    s_nxt.rd_data = VAL_W'(remain_ms);
					ADDR_EXPECT:    s_nxt.rd_data = VAL_W'($signed(expect_ms));
					default:        s_nxt.rd_data = '0;
				endcase
			end
		end

		// Stage timing runs one cycle after the comparators update, once per 5 ms
		if (s_r.tick_d)
		begin
			if (s_r.node_mode == NODE_OFF)
			begin
				s_nxt.stage = ST_NORMAL;
				s_nxt.trip_int = 1'b0;
				s_nxt.op_cnt = '0;
				s_nxt.rel_cnt = '0;
			end
			else
			begin
				case (s_r.stage)
					ST_NORMAL:
						if (pick_any)
						begin
							s_nxt.stage = blk ? ST_BLOCKED : ST_START;
							s_nxt.op_cnt = '0;
							s_nxt.rel_cnt = '0;
						end
					ST_START:
						if (pick_any && !blk)
						begin
							s_nxt.rel_cnt = '0;
							s_nxt.op_cnt = s_r.op_cnt + 1'b1;
							if (s_r.op_cnt + 1'b1 >= s_r.op_delay)
								s_nxt.trip_int = 1'b1;
						end
						else
						begin
							// Blocking after start releases through the release delay
							s_nxt.rel_cnt = s_r.rel_cnt + 1'b1;
							if (s_r.rel_cnt + 1'b1 >= s_r.rel_delay)
							begin
								s_nxt.stage = ST_NORMAL;
								s_nxt.trip_int = 1'b0;
							end
						end
					ST_BLOCKED:
						if (!pick_any || !blk)
							s_nxt.stage = ST_NORMAL;
					default:
						s_nxt.stage = ST_NORMAL;
				endcase
			end
		end
		s_nxt.start_o = (s_nxt.stage == ST_START);
		s_nxt.blocked_o = (s_nxt.stage == ST_BLOCKED);
		// Test modes show the trip in status but keep it off the output
		s_nxt.trip_o = s_nxt.trip_int && (s_nxt.node_mode != NODE_TEST) &&
			(s_nxt.node_mode != NODE_TEST_BLOCKED);
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s_r <= '0;
			s_r.ch_en <= CH_EN_RST;
			s_r.mult <= MULT_RST;
			s_r.op_delay <= OP_DELAY_RST;
			s_r.rel_delay <= REL_DELAY_RST;
			for (int k = 0; k < NCH; k++)
			begin
				s_r.level[k] <= PICKUP_RST;
				s_r.hyst[k] <= HYST_RST;
				s_r.blk_lim[k] <= -VAL_LIMIT;
			end
		end
		else
			s_r <= s_nxt;
	end

	assign rd_data = s_r.rd_data;
	assign start   = s_r.start_o;
	assign trip    = s_r.trip_o;
	assign blocked = s_r.blocked_o;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence seq_pick_idle;
		s_r.tick_d && s_r.stage == ST_NORMAL && s_r.node_mode != NODE_OFF && pick_any;
	endsequence

	sequence seq_tick_gap;
		s_r.tick ##1 !s_r.tick [*8];
	endsequence

	chk_trip_needs_start: assert property (s_r.trip_int |-> s_r.start_o)
		else $error("trip without start");
	chk_trip_after_delay: assert property ($rose(s_r.trip_int) |->
		$past(s_r.tick_d) && s_r.op_cnt >= s_r.op_delay)
		else $error("trip before operating delay");
	chk_start_entry: assert property (seq_pick_idle and !blk |=>
		s_r.start_o && !s_r.blocked_o && s_r.op_cnt == '0)
		else $error("start not entered on pick-up");
	chk_blocked_entry: assert property (seq_pick_idle and blk |=>
		s_r.blocked_o && !s_r.start_o && cond_now == COND_BLOCKED)
		else $error("blocked state not entered");
	chk_release_wait: assert property ($fell(s_r.start_o) |->
		$past(s_r.node_mode) == NODE_OFF ||
		20'($past(s_r.rel_cnt)) + 20'h1 >= 20'($past(s_r.rel_delay)))
		else $error("start released before release delay");
	chk_remain_range: assert property (s_r.start_o && !s_r.trip_int |->
		remain_ms <= 32'(MAX_DELAY_S * 1000) && remain_ms == expect_ms -
		32'(s_r.op_cnt) * 32'(TICK_TIME_MS))
		else $error("remaining time wrong");
	chk_scaled_limit: assert property ($signed(s_r.scaled[0]) <= VAL_LIMIT &&
		$signed(s_r.scaled[NCH-1]) >= -VAL_LIMIT)
		else $error("scaled magnitude out of range");
	chk_tick_spacing: assert property (s_r.tick |-> seq_tick_gap)
		else $error("processing ticks too close");
	chk_mode_hidden: assert property (rd_en && addr == ADDR_CTRL && !allow_node_mode |=>
		rd_data[2:0] == 3'h0)
		else $error("node mode visible without permission");
	chk_read_once: assert property (!rd_en |=> rd_data == '0)
		else $error("read data outside the answer cycle");
endmodule

// ### logic/psc_pkg.sv
// Constants and types of the programmable stage comparator
package psc_pkg;
	localparam int CLK_PERIOD_NS   = 4;
	localparam int TICK_TIME_NS    = 5000000;
	localparam int TICK_CYCLES     = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int TICK_TIME_MS    = 5;
	localparam int DELTA_WINDOW_MS = 20;
	localparam int DELTA_TICKS     = DELTA_WINDOW_MS / TICK_TIME_MS;
	localparam int MAX_DELAY_S     = 1800;
	localparam int MAX_DELAY_STEPS = MAX_DELAY_S * 1000 / TICK_TIME_MS;
	localparam int OP_DELAY_MS     = 40;
	localparam int REL_DELAY_MS    = 60;
	localparam int DLY_W           = 19;
	localparam int VAL_W           = 48;
	localparam int HYST_W          = 20;
	localparam int TICK_W          = 24;
	localparam int NCH             = 4;
	localparam int NMEAS           = 3;
	localparam int MULT_FRAC       = 16;
	localparam logic [DLY_W-1:0]        OP_DELAY_RST  = DLY_W'(OP_DELAY_MS / TICK_TIME_MS);
	localparam logic [DLY_W-1:0]        REL_DELAY_RST = DLY_W'(REL_DELAY_MS / TICK_TIME_MS);
	localparam logic [DLY_W-1:0]        DELAY_MAX     = DLY_W'(MAX_DELAY_STEPS);
	// Values count in steps of 0.0001, so five million is 5e10 counts
	localparam logic signed [VAL_W-1:0] VAL_LIMIT     = 48'sh000b_a43b_7400;
	localparam logic signed [VAL_W-1:0] FRAC_SCALE    = 48'sh0000_0000_2710;
	localparam logic signed [VAL_W-1:0] PICKUP_RST    = 48'sh0000_0000_0064;
	localparam logic [HYST_W-1:0]       HYST_RST      = 20'h07530;
	localparam logic [HYST_W-1:0]       HYST_MAX      = 20'h7a120;
	localparam logic signed [31:0]      PPM_SCALE     = 32'sh000f_4240;
	// Scale for ppm hysteresis in 2^-32 units; about 2.4 % above the reciprocal of one million
	localparam logic [31:0]             RECIP_PPM     = 32'h0000_112e;
	localparam logic signed [31:0]      MULT_RST      = 32'sh0001_0000;
	localparam logic [NCH-1:0]          CH_EN_RST     = 4'h1;
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_MULT      = 8'h01;
	localparam logic [7:0] ADDR_OP_DELAY  = 8'h02;
	localparam logic [7:0] ADDR_REL_DELAY = 8'h03;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_REMAIN    = 8'h05;
	localparam logic [7:0] ADDR_EXPECT    = 8'h06;
	localparam logic [2:0] CH_REGION      = 3'h1;
	localparam logic [2:0] CHOFS_MODE     = 3'h0;
	localparam logic [2:0] CHOFS_LEVEL    = 3'h1;
	localparam logic [2:0] CHOFS_HYST     = 3'h2;
	localparam logic [2:0] CHOFS_BLK      = 3'h3;
	localparam logic [2:0] CHOFS_RATIO    = 3'h4;
	localparam logic [2:0] CHOFS_SCALED   = 3'h5;
	localparam int CTRL_EN_LSB  = 4;
	localparam int STAT_START   = 2;
	localparam int STAT_TRIP    = 3;
	localparam int STAT_BLOCKED = 4;
	localparam int STAT_PICK    = 8;
	typedef enum logic [2:0] {CMP_OVER, CMP_OVER_ABS, CMP_UNDER, CMP_UNDER_ABS,
		CMP_DPCT_SGN, CMP_DPCT_ABS, CMP_DVAL_SGN, CMP_DVAL_ABS} psc_cmp_mode_type;
	typedef enum logic [2:0] {NODE_ON, NODE_BLOCKED, NODE_TEST, NODE_TEST_BLOCKED,
		NODE_OFF} psc_node_mode_type;
	typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} psc_cond_type;
	typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_BLOCKED} psc_stage_type;
endpackage

// ### logic/psc_cmp_if.sv
// Settings and pick-up result of one comparison channel
`timescale 1ns/1ps
interface psc_cmp_if;
	import psc_pkg::*;
	psc_cmp_mode_type   mode;
	logic [VAL_W-1:0]   level;
	logic [VAL_W-1:0]   blk_lim;
	logic [HYST_W-1:0]  hyst;
	logic [VAL_W-1:0]   value;
	logic               tick;
	logic               pick;
	modport cmp (input mode, input level, input blk_lim, input hyst, input value, input tick,
		output pick);
	modport ctl (output mode, output level, output blk_lim, output hyst, output value,
		output tick, input pick);
endinterface

// ### logic/psc_cmp.sv
// One comparison channel: mode decode, 20 ms history, hysteresis
`timescale 1ns/1ps
module psc_cmp
	import psc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	psc_cmp_if.cmp   bus
);
	typedef struct packed {
		logic [DELTA_TICKS-1:0][VAL_W-1:0] hist;
		logic                              pick;
	} psc_cmp_state_type;

	psc_cmp_state_type  s_r;
	psc_cmp_state_type  s_nxt;
	logic signed [95:0]  v;
	logic signed [95:0]  o;
	logic signed [95:0]  d;
	logic signed [95:0]  lvl;
	logic signed [95:0]  x;
	logic signed [95:0]  th;
	logic signed [95:0]  hy;
	logic signed [127:0] hprod;
	logic                neg;
	logic                under;
	logic                inhibit;

	always_comb
	begin
		s_nxt = s_r;
		v = 96'($signed(bus.value));
		o = 96'($signed(s_r.hist[DELTA_TICKS-1]));
		lvl = 96'($signed(bus.level));
		d = v - o;
		under = (bus.mode == CMP_UNDER) || (bus.mode == CMP_UNDER_ABS);
		case (bus.mode)
			CMP_OVER, CMP_UNDER:
			begin
				x = v;
				th = lvl;
			end
			CMP_OVER_ABS, CMP_UNDER_ABS:
			begin
				x = (v < 0) ? -v : v;
				th = lvl;
			end
			CMP_DPCT_SGN:
			begin
				x = d * 96'(PPM_SCALE);
				th = lvl * ((o < 0) ? -o : o);
			end
			CMP_DPCT_ABS:
			begin
				x = ((d < 0) ? -d : d) * 96'(PPM_SCALE);
				th = ((lvl < 0) ? -lvl : lvl) * ((o < 0) ? -o : o);
			end
			CMP_DVAL_SGN:
			begin
				x = d;
				th = lvl;
			end
			CMP_DVAL_ABS:
			begin
				x = (d < 0) ? -d : d;
				th = (lvl < 0) ? -lvl : lvl;
			end
			default:
			begin
				x = '0;
				th = '0;
			end
		endcase
		// A negative level on a signed change mode selects the falling direction
		neg = under || (((bus.mode == CMP_DPCT_SGN) || (bus.mode == CMP_DVAL_SGN)) && (lvl < 0));
		if (neg)
		begin
			x = -x;
			th = -th;
		end
		hprod = 128'((th < 0) ? -th : th) * 128'({RECIP_PPM} * 32'(bus.hyst));
		hy = 96'(hprod >>> 32);
		inhibit = under && (v < 96'($signed(bus.blk_lim)));
		if (bus.tick)
		begin
			s_nxt.hist = {s_r.hist[DELTA_TICKS-2:0], bus.value};
			s_nxt.pick = !inhibit && (s_r.pick ? (x >= th - hy) : (x > th));
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign bus.pick = s_r.pick;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_over_pick_set: assert property (bus.tick && bus.mode == CMP_OVER &&
		$signed(bus.value) > $signed(bus.level) |=> bus.pick)
		else $error("greater-than condition not picked up");
	chk_under_limit_inhibit: assert property (bus.tick && under &&
		$signed(bus.value) < $signed(bus.blk_lim) |=> !bus.pick)
		else $error("under comparison active below blocking limit");
	chk_pick_only_tick: assert property (!bus.tick |=> $stable(bus.pick))
		else $error("pick-up changed outside a processing cycle");
endmodule

// ### test/psc_stage_tb_top.sv
// Self-checking bench for the programmable stage over its register port
`timescale 1ns/1ps
module psc_stage_tb_top;
	import psc_pkg::*;
	logic              clock;
	logic              rst_n;
	logic [7:0]        addr;
	logic [VAL_W-1:0]  wr_data;
	logic              wr_en;
	logic              rd_en;
	logic [VAL_W-1:0]  rd_data;
	logic [VAL_W-1:0]  meas_one;
	logic              block_request;
	logic              allow_node_mode;
	logic              start;
	logic              trip;
	logic              blocked;
	wire logic [2:0]   outs = {blocked, trip, start};
	int                n_fail;
	int                compares;
	psc_stage #(.TICK_CYC(20)) u_dut (
		.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .measured_magnitude_one(meas_one),
		.measured_magnitude_two(48'h0), .measured_magnitude_three(48'h0),
		.block_request(block_request), .allow_node_mode(allow_node_mode),
		.start(start), .trip(trip), .blocked(blocked)
	);
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [VAL_W-1:0] seen, input logic [VAL_W-1:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [VAL_W-1:0] d);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [VAL_W-1:0] exp);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), rd_data, exp);
	endtask
	// Bounded wait for one output to reach a level, then compare it
	task automatic wt(input int sel, input logic v, input int lim);
		int i;
		i = 0;
		#1;
		while (outs[sel] !== v && i < lim)
		begin
			@(posedge clock);
			#1;
			i++;
		end
		chk($sformatf("out %0d", sel), {47'h0, outs[sel]}, {47'h0, v});
	endtask
	task automatic meas(input logic [VAL_W-1:0] v);
		@(posedge clock);
		meas_one <= v;
	endtask
	task automatic end_sim;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_fail++;
		end_sim();
	end
	initial
	begin
		n_fail = 0;
		compares = 0;
		rst_n = 1'b0;
		addr = 8'h00;
		wr_data = 48'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		meas_one = 48'h0;
		block_request = 1'b0;
		allow_node_mode = 1'b1;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		rd(ADDR_MULT, 48'h10000);
		rd(ADDR_OP_DELAY, 48'h8);
		rd(ADDR_REL_DELAY, 48'hc);
		rd(ADDR_EXPECT, 48'h28);
		rd(8'h20, 48'h0);
		rd(8'h21, 48'h64);
		rd(8'h22, 48'h7530);
		rd(8'h7f, 48'h0);
		rd(ADDR_STATUS, 48'h0);
		// Node mode: off, then an illegal code keeps it; hidden without permission
		wr(ADDR_CTRL, 48'h14);
		wr(ADDR_CTRL, 48'h15);
		rd(ADDR_CTRL, 48'h14);
		allow_node_mode <= 1'b0;
		rd(ADDR_CTRL, 48'h10);
		allow_node_mode <= 1'b1;
		wr(ADDR_CTRL, 48'h10);
		wr(ADDR_OP_DELAY, 48'hffffff);
		rd(ADDR_OP_DELAY, 48'h57e40);
		wr(8'h22, 48'hfffff);
		rd(8'h22, 48'h7a120);
		wr(8'h22, 48'h7530);
		wr(ADDR_OP_DELAY, 48'h2);
		rd(ADDR_EXPECT, 48'ha);
		wr(ADDR_REL_DELAY, 48'h3);
		wr(8'h21, 48'h3e8);
		wr(ADDR_MULT, 48'h20000);
		meas(48'h7d0);
		repeat (300) @(posedge clock);
		rd(8'h25, 48'hfa0);
		rd(8'h24, 48'h9c40);
		wt(0, 1'b1, 200);
		wt(1, 1'b1, 200);
		// The calculated channel sees the same 4000 against level 100 and picks too
		rd(ADDR_STATUS, 48'h90e);
		// Just inside the 3 % band the start must hold
		meas(48'h1ea);
		repeat (200) @(posedge clock);
		#1;
		chk("hold", {45'h0, outs}, 48'h3);
		meas(48'h1c2);
		wt(0, 1'b0, 200);
		chk("trip off", {47'h0, trip}, 48'h0);
		wr(ADDR_MULT, 48'h10000);
		block_request <= 1'b1;
		meas(48'h7d0);
		wt(2, 1'b1, 200);
		chk("no start", {47'h0, start}, 48'h0);
		block_request <= 1'b0;
		wt(0, 1'b1, 200);
		meas(48'h0);
		wt(0, 1'b0, 200);
		// Absolute over: a negative swing still picks up
		wr(8'h20, 48'h1);
		meas(-48'sd2000);
		wt(0, 1'b1, 200);
		meas(48'h0);
		wt(0, 1'b0, 200);
		// Limit first, so the under mode never sees zero unguarded
		wr(8'h23, 48'h258);
		wr(8'h20, 48'h2);
		meas(48'h1f4);
		repeat (200) @(posedge clock);
		#1;
		chk("under blk", {47'h0, start}, 48'h0);
		meas(48'h320);
		wt(0, 1'b1, 200);
		meas(48'h7d0);
		wt(0, 1'b0, 200);
		wr(8'h20, 48'h7);
		wr(8'h21, 48'h1f4);
		meas(48'h0);
		repeat (200) @(posedge clock);
		meas(48'h3e8);
		wt(0, 1'b1, 200);
		// Test mode with a negative level: trip shows in status but not on the pin
		wr(ADDR_CTRL, 48'h12);
		wr(8'h20, 48'h0);
		wr(8'h21, -48'sd1000);
		meas(-48'sd500);
		wt(0, 1'b1, 200);
		repeat (60) @(posedge clock);
		#1;
		chk("test trip", {47'h0, trip}, 48'h0);
		rd(ADDR_STATUS, 48'h10e);
		rd(ADDR_REMAIN, 48'h0);
		meas(-48'sd2000);
		wt(0, 1'b0, 200);
		wr(ADDR_CTRL, 48'h13);
		meas(-48'sd500);
		wt(2, 1'b1, 200);
		// 10 % change within four 80 ns ticks, either way; history settles first
		wr(ADDR_CTRL, 48'h10);
		wr(8'h21, 48'h186a0);
		wr(8'h20, 48'h5);
		repeat (200) @(posedge clock);
		#1;
		chk("dpct idle", {47'h0, start}, 48'h0);
		meas(-48'sd600);
		wt(0, 1'b1, 200);
		end_sim();
	end
endmodule
